/* File: esp_page_builder.sv */
// element status page framer: page header plus common descriptor part
// assumes element source and byte sink run on i_clk; fill bytes arrive
// combinationally for the index on o_byte_idx
//
// How it works
// - each page is an eight-byte header then one or more descriptors
// - header byte 0 holds the page type, never the all-types zero
// - byte 1 bit 7 set when descriptors carry primary volume tags
// - without a barcode reader the primary tag flag is always zero
// - alternate tag flag and remaining low bits of byte 1 are zero
// - bytes 2-3 give descriptor size: 16 plain, 52 with tags
// - byte 4 zero; bytes 5-7 are length times descriptor count
// - descriptors open with the two-byte element address
// - third byte exception bit: 0 normal, 1 uncertain state
// - on exception report doubt code and last trusted full and tag
// - full bit is 1 when a cartridge is held, else 0
// - descriptor bytes 4 and 5 hold sense code and qualifier
// - 83h/00h label doubt, 83h/01h label error, reader and not a legacy error emulation
// - 83h/04h marks a drive bay with no usable drive
// - native: 83h/02h magazine missing, 83h/03h full and label doubt
// - native without reader reports occupancy doubt as 83h/07h
// - native 83h/09h no label, never without a reader
// - legacy error emulations use 90h/02h and 90h/03h
// - third legacy: 83h/01h label absent, 83h/03h regardless of reader
// - type codes: 1 handler, 2 storage, 3 port, 4 drive
// - only non-empty pages; elements in ascending address order; a repeated or lower address is still sent, with o_order_err raised
// - tag field of 36 bytes present or dropped to give 16 bytes
`timescale 1ns/1ps
`include "esp_cfg.svh"

module esp_page_builder
   import esp_pkg::*;
#(
   parameter int CNT_W = 16
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   // page request
   input wire logic i_start,
   input wire logic [7:0] i_elem_type,
   input wire logic i_tag_req,
   input wire logic [CNT_W-1:0] i_desc_count,
   input wire esp_emul_t i_emul,
   input wire logic i_barcode_present,
   output logic o_start_refused,
   output logic o_busy,
   // element source
   output logic o_elem_req,
   input wire logic i_elem_valid,
   input wire logic [15:0] i_elem_addr,
   input wire logic [7:0] i_elem_status,
   input wire logic i_elem_except,
   input wire logic i_elem_full,
   input wire logic i_elem_full_known,
   input wire esp_cause_t i_elem_cause,
   output logic o_tag_use_known,
   output logic o_order_err,
   // type-specific and tag bytes
   output logic [5:0] o_byte_idx,
   input wire logic [7:0] i_fill_byte,
   // byte stream to the host adapter
   output logic o_valid,
   output logic [7:0] o_data,
   output logic o_first,
   output logic o_last,
   input wire logic i_ready
);

   esp_state_t state;
   logic [CNT_W-1:0] remaining;
   logic [7:0] page_type;
   logic tag_on;
   logic [7:0] desc_len;
   logic [23:0] byte_count;
   esp_emul_t emul;
   logic barcode;
   logic [15:0] elem_addr;
   logic [15:0] prev_addr;
   logic have_prev;
   logic [7:0] elem_status;
   logic elem_except;
   logic elem_full;
   esp_cause_t elem_cause;
   logic [7:0] sense_asc;
   logic [7:0] sense_ascq;
   logic [7:0] next_data;
   logic [7:0] next_len;
   logic ld;
   logic start_ok;
   logic hdr_end;
   logic desc_end;
   logic last_desc;
   logic take_elem;

   // true for the four reportable element types only
   function automatic logic type_ok(input logic [7:0] t);
      type_ok = (t >= `ESP_TYPE_HANDLER) && (t <= `ESP_TYPE_DRIVE);
   endfunction : type_ok

   // the output register takes a new byte when empty or drained
   assign ld = !o_valid || i_ready;

   // refuse the all-types code and empty pages
   assign start_ok = type_ok(i_elem_type) &&
                     (i_desc_count != {CNT_W{1'b0}});

   // descriptor size follows the tag decision
   assign next_len = (i_tag_req && i_barcode_present) ?
                     `ESP_LEN_TAG : `ESP_LEN_NOTAG;

   // phase end markers
   assign hdr_end = (state == ESP_HDR) && ld &&
                    (o_byte_idx == `ESP_HDR_CNT_LO);
   assign desc_end = (state == ESP_DESC) && ld &&
                     (o_byte_idx == 6'(desc_len - 8'h01));
   assign last_desc = (remaining == {{(CNT_W-1){1'b0}}, 1'b1});
   assign take_elem = (state == ESP_FETCH) && i_elem_valid;

   // page state and byte index
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state <= ESP_IDLE;
         o_byte_idx <= 6'h00;
      end
      else
      begin
         case (state)
            ESP_IDLE:
               if (i_start && start_ok)
               begin
                  state <= ESP_HDR;
                  o_byte_idx <= 6'h00;
               end
            ESP_HDR:
               if (hdr_end)
               begin
                  state <= ESP_FETCH;
                  o_byte_idx <= 6'h00;
               end
               else if (ld)
                  o_byte_idx <= o_byte_idx + 6'h01;
            ESP_FETCH:
               if (i_elem_valid)
               begin
                  state <= ESP_DESC;
                  o_byte_idx <= 6'h00;
               end
            ESP_DESC:
               if (desc_end)
               begin
                  state <= last_desc ? ESP_IDLE : ESP_FETCH;
                  o_byte_idx <= 6'h00;
               end
               else if (ld)
                  o_byte_idx <= o_byte_idx + 6'h01;
            default:
            begin
               state <= ESP_IDLE;
               o_byte_idx <= 6'h00;
            end
         endcase
      end
   end

   // page configuration, caught when a page starts
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         page_type <= `ESP_TYPE_HANDLER;
         tag_on <= 1'b0;
         desc_len <= `ESP_LEN_NOTAG;
         byte_count <= 24'h000000;
         emul <= ESP_EMUL_NATIVE;
         barcode <= 1'b0;
      end
      else if (state == ESP_IDLE && i_start && start_ok)
      begin
         page_type <= i_elem_type;
         // tag flag needs a fitted reader
         tag_on <= i_tag_req && i_barcode_present;
         desc_len <= next_len;
         byte_count <= 24'({16'h0000, next_len} * 24'(i_desc_count));
         emul <= i_emul;
         barcode <= i_barcode_present;
      end
   end

   // descriptors still to send in this page
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         remaining <= {CNT_W{1'b0}};
      else if (state == ESP_IDLE && i_start && start_ok)
         remaining <= i_desc_count;
      else if (desc_end)
         remaining <= remaining - {{(CNT_W-1){1'b0}}, 1'b1};
   end

   // request and refusal strobes, busy level
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_elem_req <= 1'b0;
         o_start_refused <= 1'b0;
         o_busy <= 1'b0;
      end
      else
      begin
         if (take_elem)
            o_elem_req <= 1'b0;
         else if (hdr_end || (desc_end && !last_desc))
            o_elem_req <= 1'b1;
         o_start_refused <= i_start && (state != ESP_IDLE || !start_ok);
         if (state == ESP_IDLE && i_start && start_ok)
            o_busy <= 1'b1;
         else if (desc_end && last_desc)
            o_busy <= 1'b0;
      end
   end

   // element capture for the descriptor about to be sent
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         elem_addr <= 16'h0000;
         elem_status <= 8'h00;
         elem_except <= 1'b0;
         elem_full <= 1'b0;
         elem_cause <= ESP_CAUSE_NONE;
         o_tag_use_known <= 1'b0;
      end
      else if (take_elem)
      begin
         elem_addr <= i_elem_addr;
         elem_status <= i_elem_status;
         elem_except <= i_elem_except;
         elem_full <= i_elem_except ? i_elem_full_known : i_elem_full;
         elem_cause <= i_elem_cause;
         // tag source told to use last trusted label
         o_tag_use_known <= i_elem_except;
      end
   end

   // address order watch across the page
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         prev_addr <= 16'h0000;
         have_prev <= 1'b0;
         o_order_err <= 1'b0;
      end
      else
      begin
         o_order_err <= 1'b0;
         if (state == ESP_IDLE && i_start && start_ok)
            have_prev <= 1'b0;
         else if (take_elem)
         begin
            o_order_err <= have_prev && (i_elem_addr <= prev_addr);
            prev_addr <= i_elem_addr;
            have_prev <= 1'b1;
         end
      end
   end

   // sense pair of the captured element
   esp_sense_select u_sense (
      .i_emul(emul),
      .i_barcode_present(barcode),
      .i_except(elem_except),
      .i_cause(elem_cause),
      .o_asc(sense_asc),
      .o_ascq(sense_ascq)
   );

   // byte at the current index of header or descriptor
   always_comb
   begin
      next_data = 8'h00;
      if (state == ESP_HDR)
      begin
         case (o_byte_idx)
            `ESP_HDR_TYPE: next_data = page_type;
            `ESP_HDR_FLAGS:
            begin
               next_data = 8'h00;
               next_data[`ESP_PTAG_BIT] = tag_on;
            end
            `ESP_HDR_LEN_HI: next_data = 8'h00;
            `ESP_HDR_LEN_LO: next_data = desc_len;
            `ESP_HDR_RSVD: next_data = 8'h00;
            `ESP_HDR_CNT_HI: next_data = byte_count[23:16];
            `ESP_HDR_CNT_MID: next_data = byte_count[15:8];
            `ESP_HDR_CNT_LO: next_data = byte_count[7:0];
            default: next_data = 8'h00;
         endcase
      end
      else if (state == ESP_DESC)
      begin
         case (o_byte_idx)
            `ESP_DSC_ADDR_HI: next_data = elem_addr[15:8];
            `ESP_DSC_ADDR_LO: next_data = elem_addr[7:0];
            `ESP_DSC_STATUS:
            begin
               next_data = elem_status;
               next_data[`ESP_EXCEPT_BIT] = elem_except;
               next_data[`ESP_FULL_BIT] = elem_full;
            end
            `ESP_DSC_RSVD: next_data = 8'h00;
            `ESP_DSC_ASC: next_data = sense_asc;
            `ESP_DSC_ASCQ: next_data = sense_ascq;
            // type fields and tag from the fill source
            default: next_data = i_fill_byte;
         endcase
      end
   end

   // output byte register with back-pressure
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_valid <= 1'b0;
         o_data <= 8'h00;
         o_first <= 1'b0;
         o_last <= 1'b0;
      end
      else if (ld)
      begin
         o_valid <= (state == ESP_HDR) || (state == ESP_DESC);
         o_data <= next_data;
         o_first <= (state == ESP_HDR) && (o_byte_idx == `ESP_HDR_TYPE);
         o_last <= desc_end && last_desc;
      end
   end

endmodule : esp_page_builder

/* File: esp_cfg.svh */
// byte layout, field positions and code values of element status pages
// included by the page builder and the sense selector; definitions only
`ifndef ESP_CFG_SVH
`define ESP_CFG_SVH

// page header byte positions
`define ESP_HDR_TYPE 6'h00
`define ESP_HDR_FLAGS 6'h01
`define ESP_HDR_LEN_HI 6'h02
`define ESP_HDR_LEN_LO 6'h03
`define ESP_HDR_RSVD 6'h04
`define ESP_HDR_CNT_HI 6'h05
`define ESP_HDR_CNT_MID 6'h06
`define ESP_HDR_CNT_LO 6'h07

// descriptor byte positions of the common part
`define ESP_DSC_ADDR_HI 6'h00
`define ESP_DSC_ADDR_LO 6'h01
`define ESP_DSC_STATUS 6'h02
`define ESP_DSC_RSVD 6'h03
`define ESP_DSC_ASC 6'h04
`define ESP_DSC_ASCQ 6'h05

// bit positions
`define ESP_PTAG_BIT 7
`define ESP_ATAG_BIT 6
`define ESP_EXCEPT_BIT 2
`define ESP_FULL_BIT 0

// element type codes
`define ESP_TYPE_ALL 8'h00
`define ESP_TYPE_HANDLER 8'h01
`define ESP_TYPE_STORAGE 8'h02
`define ESP_TYPE_PORT 8'h03
`define ESP_TYPE_DRIVE 8'h04

// descriptor lengths in bytes, with and without the volume tag
`define ESP_LEN_NOTAG 8'h10
`define ESP_LEN_TAG 8'h34

// sense codes and qualifiers
`define ESP_ASC_NONE 8'h00
`define ESP_ASC_VENDOR 8'h83
`define ESP_ASC_LEGACY 8'h90
`define ESP_Q_NONE 8'h00
`define ESP_Q_LABEL_DOUBT 8'h00
`define ESP_Q_LABEL_ERR 8'h01
`define ESP_Q_MAG_ABSENT 8'h02
`define ESP_Q_FULL_LABEL 8'h03
`define ESP_Q_DRIVE_ABSENT 8'h04
`define ESP_Q_FULL_ONLY 8'h07
`define ESP_Q_NO_LABEL 8'h09

`endif

/* File: esp_pkg.sv */
// types shared by the element status page builder
// assumes esp_cfg.svh carries all numeric constants
package esp_pkg;

   // emulation selections
   typedef enum logic [1:0] {
      ESP_EMUL_NATIVE,
      ESP_EMUL_LEGACY_E,
      ESP_EMUL_LEGACY_I,
      ESP_EMUL_LEGACY_T
   } esp_emul_t;

   // exception causes reported by the element source
   typedef enum logic [2:0] {
      ESP_CAUSE_NONE,
      ESP_CAUSE_LABEL_DOUBT,
      ESP_CAUSE_LABEL_ERR,
      ESP_CAUSE_DRIVE_ABSENT,
      ESP_CAUSE_MAG_ABSENT,
      ESP_CAUSE_FULL_DOUBT,
      ESP_CAUSE_NO_LABEL
   } esp_cause_t;

   // page framer states
   typedef enum logic [1:0] {
      ESP_IDLE,
      ESP_HDR,
      ESP_FETCH,
      ESP_DESC
   } esp_state_t;

endpackage : esp_pkg

/* File: esp_sense_select.sv */
// sense code pair selection from cause, emulation and reader presence
// combinational; inputs are held stable by the page builder
`timescale 1ns/1ps
`include "esp_cfg.svh"

module esp_sense_select
   import esp_pkg::*;
(
   input wire esp_emul_t i_emul,
   input wire logic i_barcode_present,
   input wire logic i_except,
   input wire esp_cause_t i_cause,
   output logic [7:0] o_asc,
   output logic [7:0] o_ascq
);

   logic legacy_ei;
   logic label_ok;

   // the two legacy error emulations never report label codes
   assign legacy_ei = (i_emul == ESP_EMUL_LEGACY_E) ||
                      (i_emul == ESP_EMUL_LEGACY_I);
   assign label_ok = i_barcode_present && !legacy_ei;

   // pick the pair; no exception or unreportable cause gives zeros
   always_comb
   begin
      o_asc = `ESP_ASC_NONE;
      o_ascq = `ESP_Q_NONE;
      if (i_except)
      begin
         case (i_cause)
            ESP_CAUSE_LABEL_DOUBT:
               if (label_ok)
               begin
                  o_asc = `ESP_ASC_VENDOR;
                  o_ascq = `ESP_Q_LABEL_DOUBT;
               end
            ESP_CAUSE_LABEL_ERR:
               if (label_ok)
               begin
                  o_asc = `ESP_ASC_VENDOR;
                  o_ascq = `ESP_Q_LABEL_ERR;
               end
            ESP_CAUSE_DRIVE_ABSENT:
            begin
               o_asc = `ESP_ASC_VENDOR;
               o_ascq = `ESP_Q_DRIVE_ABSENT;
            end
            ESP_CAUSE_MAG_ABSENT:
            begin
               o_asc = legacy_ei ? `ESP_ASC_LEGACY : `ESP_ASC_VENDOR;
               o_ascq = `ESP_Q_MAG_ABSENT;
            end
            ESP_CAUSE_FULL_DOUBT:
            begin
               o_asc = legacy_ei ? `ESP_ASC_LEGACY : `ESP_ASC_VENDOR;
               o_ascq = `ESP_Q_FULL_LABEL;
               if (i_emul == ESP_EMUL_NATIVE && !i_barcode_present)
                  o_ascq = `ESP_Q_FULL_ONLY;
            end
            ESP_CAUSE_NO_LABEL:
               if (label_ok)
               begin
                  o_asc = `ESP_ASC_VENDOR;
                  o_ascq = (i_emul == ESP_EMUL_LEGACY_T) ?
                           `ESP_Q_LABEL_ERR : `ESP_Q_NO_LABEL;
               end
            default:
            begin
               o_asc = `ESP_ASC_NONE;
               o_ascq = `ESP_Q_NONE;
            end
         endcase
      end
   end

endmodule : esp_sense_select

/* File: esp_page_builder_sva.sv */
// port-level checks of the page builder, bound after the module
// assumes one clock domain and an async active-high reset
`timescale 1ns/1ps
module esp_page_builder_sva
#(
   parameter int CNT_W = 16
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_start,
   input wire logic [7:0] i_elem_type,
   input wire logic i_tag_req,
   input wire logic [CNT_W-1:0] i_desc_count,
   input wire logic i_barcode_present,
   input wire logic o_start_refused,
   input wire logic o_busy,
   input wire logic o_elem_req,
   input wire logic i_elem_valid,
   input wire logic [15:0] i_elem_addr,
   input wire logic [7:0] i_elem_status,
   input wire logic i_elem_except,
   input wire logic i_elem_full,
   input wire logic i_elem_full_known,
   input wire logic o_tag_use_known,
   input wire logic o_valid,
   input wire logic [7:0] o_data,
   input wire logic o_first,
   input wire logic o_last,
   input wire logic i_ready
);
   logic tag_q, exc_q;
   logic [7:0] ty_q, len_q, st_q, ex, dp;
   logic [15:0] ad_q;
   logic [23:0] cnt_q;
   logic [3:0] hc;
   wire logic acc = o_valid && i_ready;
   wire logic tk = o_elem_req && i_elem_valid;
   wire logic ptag = i_tag_req && i_barcode_present;
   wire logic idle = !o_busy && !o_valid;
   wire logic okty = i_elem_type >= 8'h01 && i_elem_type <= 8'h04;
   wire logic go = i_start && idle && okty && |i_desc_count;
   wire logic bad = i_start && idle && (!okty || i_desc_count == '0);

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   // page settings as taken with the start
   always_ff @(posedge i_clk)
      if (go)
      begin
         ty_q <= i_elem_type;
         tag_q <= ptag;
         len_q <= ptag ? 8'h34 : 8'h10;
         cnt_q <= 24'(i_desc_count) * (ptag ? 24'h34 : 24'h10);
      end

   // element fields as the builder takes them
   always_ff @(posedge i_clk)
      if (tk)
      begin
         ad_q <= i_elem_addr;
         exc_q <= i_elem_except;
         st_q <= {i_elem_status[7:3], i_elem_except, i_elem_status[1],
            i_elem_except ? i_elem_full_known : i_elem_full};
      end

   // header byte position, saturating at the first descriptor
   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
         hc <= 4'h0;
      else if (acc)
         hc <= o_last ? 4'h0 : (hc == 4'h8 ? hc : hc + 4'h1);

   // byte position inside the current descriptor
   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
         dp <= 8'h00;
      else if (acc)
         dp <= (o_last || hc != 4'h8 || dp == len_q - 8'h01) ? 8'h00
            : dp + 8'h01;

   // expected header byte or common descriptor byte
   always_comb
      case (hc)
         4'h0: ex = ty_q;
         4'h1: ex = {tag_q, 7'h00};
         4'h3: ex = len_q;
         4'h5: ex = cnt_q[23:16];
         4'h6: ex = cnt_q[15:8];
         4'h7: ex = cnt_q[7:0];
         4'h8: ex = dp == 8'h00 ? ad_q[15:8] : dp == 8'h01 ? ad_q[7:0]
            : dp == 8'h02 ? st_q : 8'h00;
         default: ex = 8'h00;
      endcase

   AST_START: assert property (go |=> o_busy && !o_start_refused
      ##1 o_valid && o_first) else $error("page start not answered");
   AST_REFUSE: assert property (bad |=> o_start_refused && !o_busy)
      else $error("bad start not refused");
   AST_BUSY: assert property (i_start && o_busy |=> o_start_refused)
      else $error("start while busy not refused");
   AST_HOLD: assert property (o_valid && !i_ready |=>
      o_valid && $stable(o_data)) else $error("byte lost while stalled");
   AST_FIRST: assert property (o_valid && o_first |->
      hc == 4'h0 && o_data inside {[8'h01:8'h04]}) else $error("bad type");
   AST_HDR: assert property (o_valid && hc != 4'h8 |-> o_data == ex)
      else $error("header byte wrong");
   AST_DESC: assert property (o_valid && hc == 4'h8 && dp < 8'h04
      |-> o_data == ex) else $error("descriptor byte wrong");
   AST_SENSE0: assert property (o_valid && hc == 4'h8 && !exc_q
      && (dp == 8'h04 || dp == 8'h05) |-> o_data == 8'h00)
      else $error("sense set without exception");
   AST_LAST: assert property (o_valid && o_last |-> !o_busy
      && hc == 4'h8 && dp == len_q - 8'h01) else $error("last misplaced");
   AST_TAKE: assert property (tk |=> !o_elem_req
      && o_tag_use_known == $past(i_elem_except))
      else $error("element take not answered");

   COV_STALL: cover property (o_valid && !i_ready);
   COV_EXC: cover property (tk && i_elem_except);
   COV_REF: cover property (o_start_refused);
endmodule : esp_page_builder_sva

bind esp_page_builder esp_page_builder_sva #(.CNT_W(CNT_W))
   i_esp_page_builder_sva (.*);

/* File: esp_host_model.sv */
// host adapter model: takes status bytes into memory
// assumes the bench clears the byte count at each page start
`timescale 1ns/1ps
module esp_host_model
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_stall,
   input wire logic i_clear,
   input wire logic i_valid,
   input wire logic [7:0] i_data,
   output logic o_ready
);
   logic [7:0] mem [0:255];
   logic [7:0] cnt;

   // ready toggles while stalling so each byte loaded behind an accepted one waits once
   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
         o_ready <= 1'b0;
      else
         o_ready <= i_stall ? !o_ready : 1'b1;

   // store each accepted byte in arrival order
   always_ff @(posedge i_clk)
      if (i_clear)
         cnt <= 8'h00;
      else if (i_valid && o_ready)
      begin
         mem[cnt] <= i_data;
         cnt <= cnt + 8'h01;
      end
endmodule : esp_host_model

/* File: esp_page_builder_tb.sv */
// self-checking bench of the page builder with a host model
// assumes inputs change at the falling edge of a 10 MHz clock
`timescale 1ns/1ps
module esp_page_builder_tb;
   import esp_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_start = 1'b0;
   logic [7:0] i_elem_type = 8'h01;
   logic i_tag_req = 1'b0;
   logic [15:0] i_desc_count = 16'h0001;
   esp_emul_t i_emul = ESP_EMUL_NATIVE;
   logic i_barcode_present = 1'b0;
   logic i_elem_valid = 1'b0;
   logic [15:0] i_elem_addr = 16'h0000;
   logic [7:0] i_elem_status = 8'h00;
   logic i_elem_except = 1'b0;
   logic i_elem_full = 1'b0;
   logic i_elem_full_known = 1'b0;
   esp_cause_t i_elem_cause = ESP_CAUSE_NONE;
   logic i_stall = 1'b0;
   logic i_clear = 1'b0;
   logic o_start_refused, o_busy, o_elem_req, o_tag_use_known;
   logic o_order_err, o_valid, o_first, o_last, i_ready;
   logic [5:0] o_byte_idx;
   logic [7:0] o_data;
   wire logic [7:0] i_fill_byte = {2'b00, o_byte_idx} ^ 8'ha5;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;

   esp_page_builder #(.CNT_W(16)) i_esp_page_builder (.*);
   esp_host_model i_esp_host_model (.i_clk(i_clk), .i_rst(i_rst),
      .i_stall(i_stall), .i_clear(i_clear), .i_valid(o_valid),
      .i_data(o_data), .o_ready(i_ready));

   // clock and hang limit
   always #50 i_clk = ~i_clk;
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         miscompares++;
         report_and_stop();
      end
   end

   task automatic report_and_stop;
      if (miscompares == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // code pair expected for a cause under an emulation
   function automatic logic [15:0] sense(input esp_emul_t em,
         input logic bc, input esp_cause_t c);
      logic nat, leg;
      nat = (em == ESP_EMUL_NATIVE);
      leg = (em == ESP_EMUL_LEGACY_E) || (em == ESP_EMUL_LEGACY_I);
      case (c)
         ESP_CAUSE_LABEL_DOUBT: sense = bc && !leg ? 16'h8300 : 16'h0000;
         ESP_CAUSE_LABEL_ERR: sense = bc && !leg ? 16'h8301 : 16'h0000;
         ESP_CAUSE_DRIVE_ABSENT: sense = 16'h8304;
         ESP_CAUSE_MAG_ABSENT: sense = leg ? 16'h9002 : 16'h8302;
         ESP_CAUSE_FULL_DOUBT: sense = leg ? 16'h9003
            : (nat && !bc) ? 16'h8307 : 16'h8303;
         ESP_CAUSE_NO_LABEL: sense = (!bc || leg) ? 16'h0000
            : nat ? 16'h8309 : 16'h8301;
         default: sense = 16'h0000;
      endcase
   endfunction : sense

   // one page: start, feed elements, then compare every byte
   task automatic run_page(input logic [7:0] ty, input logic tg, bc,
         input esp_emul_t em, input int n, step, input logic vary, dup);
      logic [7:0] len, h [0:7], d [0:5], st [0:7];
      logic [15:0] a [0:7];
      logic [15:0] sn;
      logic [23:0] cnt;
      esp_cause_t cs [0:7];
      int p;
      len = (tg && bc) ? 8'h34 : 8'h10;
      cnt = 24'(n) * 24'(len);
      @(negedge i_clk);
      i_elem_type = ty;
      i_tag_req = tg;
      i_barcode_present = bc;
      i_emul = em;
      i_desc_count = 16'(n);
      i_start = 1'b1;
      i_clear = 1'b1;
      @(negedge i_clk);
      i_start = dup;
      i_clear = 1'b0;
      chk(8'(o_busy), 8'h01);
      if (dup)
      begin
         @(negedge i_clk);
         i_start = 1'b0;
         chk(8'(o_start_refused), 8'h01);
      end
      for (int i = 0; i < n; i++)
      begin
         while (o_elem_req !== 1'b1)
            @(negedge i_clk);
         cs[i] = vary ? esp_cause_t'(i % 7) : ESP_CAUSE_NONE;
         a[i] = 16'h0100 + 16'(i * step);
         i_elem_addr = a[i];
         i_elem_status = a[i][7:0] ^ 8'h5a;
         i_elem_except = (cs[i] != ESP_CAUSE_NONE);
         i_elem_full = i[0];
         i_elem_full_known = !i[0];
         i_elem_cause = cs[i];
         st[i] = {i_elem_status[7:3], i_elem_except, i_elem_status[1],
            i_elem_except ? i_elem_full_known : i_elem_full};
         i_elem_valid = 1'b1;
         @(negedge i_clk);
         i_elem_valid = 1'b0;
         chk(8'(o_order_err), 8'(i > 0 && step <= 0));
         chk(8'(o_tag_use_known), 8'(i_elem_except));
      end
      while (i_esp_host_model.cnt !== 8'(cnt + 24'h8))
         @(negedge i_clk);
      h = '{ty, {tg && bc, 7'h00}, 8'h00, len, 8'h00, cnt[23:16],
         cnt[15:8], cnt[7:0]};
      for (int j = 0; j < 8; j++)
         chk(i_esp_host_model.mem[j], h[j]);
      for (int i = 0; i < n; i++)
      begin
         p = 8 + i * int'(len);
         sn = sense(em, bc, cs[i]);
         d = '{a[i][15:8], a[i][7:0], st[i], 8'h00, sn[15:8], sn[7:0]};
         for (int j = 0; j < 6; j++)
            chk(i_esp_host_model.mem[p + j], d[j]);
         for (int j = 6; j < int'(len); j++)
            chk(i_esp_host_model.mem[p + j], 8'(j) ^ 8'ha5);
      end
   endtask : run_page

   // every type, tags on, host stalling, one start while busy
   task automatic sc_types;
      i_stall = 1'b1;
      for (int t = 1; t < 5; t++)
         run_page(8'(t), 1'b1, 1'b1, ESP_EMUL_NATIVE, 2, 3, 1'b0,
            t == 2);
      i_stall = 1'b0;
   endtask : sc_types

   // tags asked for on a unit without a reader
   task automatic sc_no_reader;
      run_page(8'h02, 1'b1, 1'b0, ESP_EMUL_LEGACY_E, 3, 1, 1'b1,
         1'b0);
   endtask : sc_no_reader

   // every cause under every emulation, reader in and out
   task automatic sc_sense;
      for (int e = 0; e < 4; e++)
         for (int b = 0; b < 2; b++)
            run_page(8'h04, 1'b0, 1'(b), esp_emul_t'(e), 7, 5, 1'b1,
               1'b0);
   endtask : sc_sense

   // descending addresses are flagged
   task automatic sc_order;
      run_page(8'h03, 1'b1, 1'b1, ESP_EMUL_LEGACY_T, 3, -2, 1'b0,
         1'b0);
   endtask : sc_order

   // all-types code, unknown type and empty page are refused
   task automatic sc_refuse;
      logic [7:0] ty [0:2] = '{8'h00, 8'h05, 8'h02};
      for (int k = 0; k < 3; k++)
      begin
         @(negedge i_clk);
         i_elem_type = ty[k];
         i_desc_count = (k == 2) ? 16'h0000 : 16'h0001;
         i_start = 1'b1;
         @(negedge i_clk);
         i_start = 1'b0;
         chk(8'(o_start_refused), 8'h01);
         chk(8'(o_busy), 8'h00);
      end
      repeat (3) @(negedge i_clk);
      chk(8'(o_valid), 8'h00);
   endtask : sc_refuse

   // reset, then the scenarios in turn
   initial
   begin
      repeat (8) @(negedge i_clk);
      i_rst = 1'b0;
      sc_types();
      sc_no_reader();
      sc_sense();
      sc_order();
      sc_refuse();
      report_and_stop();
   end
endmodule : esp_page_builder_tb
